// >>> common/bms_pkg.sv
// shared types of the bridge measurement sequencer
package bms_pkg;

  typedef enum logic [2:0] {
    BMS_IDLE  = 3'b000,
    BMS_WAIT  = 3'b001,
    BMS_START = 3'b010,
    BMS_MEAS  = 3'b011,
    BMS_DONE  = 3'b100
  } bms_seq_t;

  typedef enum logic [2:0] {
    BMS_D_IDLE = 3'b000,
    BMS_D_CHG1 = 3'b001,
    BMS_D_DIS1 = 3'b010,
    BMS_D_CHG2 = 3'b011,
    BMS_D_DIS2 = 3'b100
  } bms_dis_t;

  // config word: run, dual full sensor, difference, pair select
  typedef struct packed {
    logic       run;
    logic       dual;
    logic       diff;
    logic [1:0] sel;
  } bms_cfg_t;

  // element pins a1 a2 b1 b2 c1 c2 d1 d2 (bit 0 = a1)
  typedef struct packed {
    logic [7:0] drv;
    logic [7:0] oe_n;
  } bms_pins_t;

  typedef struct packed {
    logic [1:0] drv;
    logic [1:0] oe_n;
  } bms_charge_t;

endpackage : bms_pkg

// >>> common/bms_regs.svh
// register offsets, field positions, reset values and timing of the measurement sequencer
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH
`define BMS_CLK_HZ        10000000
`define BMS_OFS_CONFIG    8'h00
`define BMS_OFS_CLASSIC   8'h04
`define BMS_OFS_AVG1      8'h08
`define BMS_OFS_AVG2      8'h0c
`define BMS_OFS_CYCLE     8'h10
`define BMS_OFS_COMMAND   8'h14
`define BMS_OFS_STATUS    8'h18
`define BMS_OFS_RESULT0   8'h1c
`define BMS_OFS_RESULT1   8'h20
`define BMS_OFS_RESULT    8'h24
`define BMS_CFG_WIDTH     5
`define BMS_STAT_FLAG_BIT 0
`define BMS_STAT_BUSY_BIT 1
`define BMS_STAT_SENS_BIT 31
`define BMS_OP_SENSOR1    8'h08
`define BMS_OP_SENSOR2    8'h09
`define BMS_CFG_RST       5'h00
`define BMS_AVG1_RST      12'h001
`define BMS_AVG2_RST      12'h000
`define BMS_CYCLE_RST     16'h0064
`define BMS_CHARGE_NS     2000
`define BMS_DISCH_MAX_NS  100000
`endif

// >>> dv/bms_bridge_model.sv
// bridge and comparator model: discharge time set by element index
module bms_bridge_model (
  // clock
  input  wire logic            clock_in,
  // pins from the sequencer
  input  bms_pkg::bms_charge_t charge_in,
  input  bms_pkg::bms_pins_t   elem_in,
  // comparator levels
  output logic [1:0]           level_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int         cnt = 0;
  int         lim;
  logic [7:0] low;
  always_comb
  begin
    low = ~elem_in.oe_n & ~elem_in.drv;
    lim = 0;
    for (int i = 7; i >= 0; i--)
      if (low[i])
        lim = 8 + i * i;
  end
  always @(posedge clock_in)
  begin
    if ((charge_in.drv & ~charge_in.oe_n) != 2'b00 || low == 8'h00)
      cnt <= 0;
    else
      cnt <= cnt + 1;
  end
  assign level_out = (low != 8'h00 && cnt >= lim) ? 2'b00 : 2'b11;
endmodule : bms_bridge_model

// >>> dv/tb_bridge_measurement_sequencer.sv
// self-checking bench of the bridge measurement sequencer
`include "bms_regs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_bridge_measurement_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ALL = 32'hffffffff;
  logic                 clock_in = 1'b0;
  logic                 rst_in = 1'b1;
  logic [7:0]           paddr = 8'h00;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 err;
  logic                 flag;
  logic                 sid;
  logic [1:0]           level;
  bms_pkg::bms_charge_t chg;
  bms_pkg::bms_pins_t   elem;
  int                   mismatches = 0;
  int                   check_count = 0;
  always #50 clock_in = ~clock_in;
  bms_sequencer DUT (.clock_in(clock_in), .rst_in(rst_in), .paddr_in(paddr), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .comparator_input_pin_in(level),
    .capacitor_charge_pin_out(chg), .element_pin_out(elem), .result_flag_out(flag), .sensor_id_out(sid));
  bms_bridge_model bridge (.clock_in(clock_in), .charge_in(chg), .elem_in(elem), .level_out(level));
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clock_in);
    penable <= 1'b1;
    do
      @(posedge clock_in);
    while (pready !== 1'b1 && n++ < 20);
    q = prdata;
    err = pslverr;
    if (n >= 20)
      mismatches++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock_in);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(a, 1'b1, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    apb(a, 1'b0, 32'h0, q);
    `CHK(q & m, e)
  endtask : rd
  task automatic nxt;
    int n;
    n = 0;
    wr(`BMS_OFS_STATUS, 32'h1);
    while (flag !== 1'b1 && n++ < 5000)
      @(posedge clock_in);
    if (n >= 5000)
      mismatches++;
  endtask : nxt
  task automatic meas(input logic [31:0] cfg);
    logic [31:0] q;
    int          n;
    n = 0;
    wr(`BMS_OFS_CONFIG, 32'h0);
    // let a running sequence drain before the new setting starts
    do
      apb(`BMS_OFS_STATUS, 1'b0, 32'h0, q);
    while (q[`BMS_STAT_BUSY_BIT] !== 1'b0 && n++ < 1000);
    if (n >= 1000)
      mismatches++;
    wr(`BMS_OFS_CONFIG, cfg);
    nxt();
  endtask : meas
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial
  begin
    #5000000;
    mismatches++;
    complete_run();
  end
  initial
  begin
    repeat (4) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    rd(`BMS_OFS_AVG1, ALL, 32'h1);
    rd(`BMS_OFS_CYCLE, ALL, 32'h64);
    rd(`BMS_OFS_AVG2, ALL, 32'h0);
    rd(8'h40, ALL, 32'h0);
    `CHK(err, 1'b1)
    wr(`BMS_OFS_AVG1, 32'h2);
    wr(`BMS_OFS_CYCLE, 32'h0);
    meas(32'h11);
    rd(`BMS_OFS_RESULT0, ALL, 32'hfffffff8);
    rd(`BMS_OFS_RESULT, ALL, 32'hfffffff8);
    meas(32'h12);
    rd(`BMS_OFS_RESULT, ALL, 32'hffffffd8);
    meas(32'h17);
    rd(`BMS_OFS_RESULT1, ALL, 32'hffffffd8);
    rd(`BMS_OFS_RESULT, ALL, 32'h20);
    meas(32'h13);
    rd(`BMS_OFS_RESULT, ALL, 32'hffffffd0);
    meas(32'h10);
    rd(`BMS_OFS_RESULT, ALL, 32'hffffffd0);
    wr(`BMS_OFS_CLASSIC, 32'h1);
    rd(`BMS_OFS_CLASSIC, ALL, 32'h1);
    meas(32'h1b);
    `CHK(sid, 1'b0)
    rd(`BMS_OFS_RESULT0, ALL, 32'hfffffff8);
    wr(`BMS_OFS_COMMAND, 32'(`BMS_OP_SENSOR2));
    nxt();
    rd(`BMS_OFS_STATUS, 32'h80000000, 32'h80000000);
    rd(`BMS_OFS_RESULT0, ALL, 32'hfffffff0);
    nxt();
    `CHK(sid, 1'b0)
    wr(`BMS_OFS_AVG2, 32'h3);
    meas(32'h1b);
    `CHK(sid, 1'b0)
    wr(`BMS_OFS_COMMAND, 32'(`BMS_OP_SENSOR2));
    nxt();
    `CHK(sid, 1'b0)
    nxt();
    rd(`BMS_OFS_RESULT0, ALL, 32'hffffffe8);
    `CHK(sid, 1'b1)
    nxt();
    `CHK(sid, 1'b1)
    complete_run();
  end
endmodule : tb_bridge_measurement_sequencer

// >>> logic/bms_average.sv
// running sum of one half sensor's discharge time differences
module bms_average #(
  parameter int unsigned TW = 16,
  parameter int unsigned SW = 32
) (
  // clock and reset
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  // samples
  input  wire logic                 clr_in,
  input  wire logic                 add_in,
  input  wire logic [TW-1:0]        t1_in,
  input  wire logic [TW-1:0]        t2_in,
  // sum
  output logic signed [SW-1:0]      sum_out
);

  logic signed [TW:0] diff;

  assign diff = $signed({1'b0, t1_in}) - $signed({1'b0, t2_in});

  always_ff @(posedge clock_in)
  begin
    if (rst_in || clr_in)
      sum_out <= '0;
    else if (add_in)
      sum_out <= sum_out + SW'(diff);
  end

endmodule : bms_average

// >>> logic/bms_discharge.sv
// one measurement: charge the capacitor before each discharge, through each element in turn
`include "bms_regs.svh"
module bms_discharge #(
  parameter int unsigned TW = 16
) (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // control
  input  wire logic              start_in,
  input  wire logic [7:0]        mask1_in,
  input  wire logic [7:0]        mask2_in,
  input  wire logic              classic_in,
  input  wire logic              port_in,
  input  wire logic              sense_in,
  // pins
  output bms_pkg::bms_pins_t     elem_out,
  output bms_pkg::bms_charge_t   charge_out,
  // results
  output logic [TW-1:0]          time1_out,
  output logic [TW-1:0]          time2_out,
  output logic                   done_out
);

  localparam int CHG_CYC = (`BMS_CHARGE_NS * (`BMS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int MAX_CYC = (`BMS_DISCH_MAX_NS * (`BMS_CLK_HZ / 1000000)) / 1000;

  bms_pkg::bms_dis_t st_q;
  logic [TW-1:0]     cnt_q;
  logic              chg_end;
  logic              dis_end;

  assign chg_end = (cnt_q == TW'(CHG_CYC - 1));
  assign dis_end = !sense_in || (cnt_q == TW'(MAX_CYC - 1));

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      st_q  <= bms_pkg::BMS_D_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      unique case (st_q)
        bms_pkg::BMS_D_IDLE:
        begin
          cnt_q <= '0;
          if (start_in)
            st_q <= bms_pkg::BMS_D_CHG1;
        end
        bms_pkg::BMS_D_CHG1:
        begin
          cnt_q <= chg_end ? '0 : cnt_q + 1'b1;
          if (chg_end)
            st_q <= bms_pkg::BMS_D_DIS1;
        end
        bms_pkg::BMS_D_DIS1:
        begin
          cnt_q <= dis_end ? '0 : cnt_q + 1'b1;
          if (dis_end)
            st_q <= bms_pkg::BMS_D_CHG2;
        end
        bms_pkg::BMS_D_CHG2:
        begin
          cnt_q <= chg_end ? '0 : cnt_q + 1'b1;
          if (chg_end)
            st_q <= bms_pkg::BMS_D_DIS2;
        end
        bms_pkg::BMS_D_DIS2:
        begin
          cnt_q <= dis_end ? '0 : cnt_q + 1'b1;
          if (dis_end)
            st_q <= bms_pkg::BMS_D_IDLE;
        end
        default:
          st_q <= bms_pkg::BMS_D_IDLE;
      endcase
    end
  end

  // discharge times and completion pulse
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      time1_out <= '0;
      time2_out <= '0;
      done_out  <= 1'b0;
    end
    else
    begin
      done_out <= (st_q == bms_pkg::BMS_D_DIS2) && dis_end;
      if ((st_q == bms_pkg::BMS_D_DIS1) && dis_end)
        time1_out <= cnt_q + 1'b1;
      if ((st_q == bms_pkg::BMS_D_DIS2) && dis_end)
        time2_out <= cnt_q + 1'b1;
    end
  end

  // pin drive; classic divider holds the opposite arm high
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      elem_out   <= '{drv: 8'h00, oe_n: 8'hff};
      charge_out <= '{drv: 2'h0, oe_n: 2'h3};
    end
    else
    begin
      charge_out.drv  <= 2'h0;
      charge_out.oe_n <= 2'h3;
      elem_out.drv    <= 8'h00;
      elem_out.oe_n   <= 8'hff;
      if ((st_q == bms_pkg::BMS_D_CHG1) || (st_q == bms_pkg::BMS_D_CHG2))
      begin
        charge_out.drv[port_in]  <= 1'b1;
        charge_out.oe_n[port_in] <= 1'b0;
      end
      else if (st_q == bms_pkg::BMS_D_DIS1)
      begin
        elem_out.drv  <= classic_in ? mask2_in : 8'h00;
        elem_out.oe_n <= ~(mask1_in | (classic_in ? mask2_in : 8'h00));
      end
      else if (st_q == bms_pkg::BMS_D_DIS2)
      begin
        elem_out.drv  <= classic_in ? mask1_in : 8'h00;
        elem_out.oe_n <= ~(mask2_in | (classic_in ? mask1_in : 8'h00));
      end
    end
  end

  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  a_charge_first: assert property (st_q == bms_pkg::BMS_D_IDLE && start_in |=> ##1 !charge_out.oe_n[$past(port_in, 2)])
    else $error("capacitor not charged first");

endmodule : bms_discharge

// >>> logic/bms_sequencer.sv
// bridge measurement sequencer: APB registers, sensor selection and averaging
//
// How it works
// - select 1/2 measures half 1/half 2
// - select 0 single comparator, 3 interleaved
// - interleaved halves alternate, each keeps delivering
// - difference enable subtracts the two halves
// - dual enable chooses one or two sensors
// - dual select: both, 1, 2, both interleaved
// - dual mode drives each element one pin
// - second count zero: auto, else command
// - auto mode alternates sensors, first count
// - flag set after every full sensor result
// - status top bit names the sensor
// - auto mode starts other sensor unprompted
// - opcodes 08/09 pick sensor 1/2
// - command mode: sensor 2 uses second count
// - switch request waits for current result
// - selected sensor repeats until switched
// - both sensors share one cycle time
// - classic enable drives four-arm bridge
// - classic mode combines with all sequencing
// - charge before each discharge through the two elements
//
// The APB slave port and the placing of the registers were left to the implementer.
`include "bms_regs.svh"
module bms_sequencer #(
  parameter int unsigned TW = 16,
  parameter int unsigned SW = 32
) (
  // clock and reset
  input  wire logic              clock_in,
  input  wire logic              rst_in,
  // apb slave
  input  wire logic [7:0]        paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // analogue side
  input  wire logic [1:0]        comparator_input_pin_in,
  output bms_pkg::bms_charge_t   capacitor_charge_pin_out,
  output bms_pkg::bms_pins_t     element_pin_out,
  // status
  output logic                   result_flag_out,
  output logic                   sensor_id_out
);

  bms_pkg::bms_cfg_t  cfg_q;
  logic               classic_q;
  logic [11:0]        avg1_q;
  logic [11:0]        avg2_q;
  logic [15:0]        cycle_q;
  logic               cmd_sensor_q;
  bms_pkg::bms_seq_t  st_q;
  logic               half_q;
  logic               sensor_q;
  logic [11:0]        sample_q;
  logic [15:0]        timer_q;
  logic               status_sensor_q;
  logic signed [SW-1:0] result0_q;
  logic signed [SW-1:0] result1_q;
  logic signed [SW-1:0] result_q;
  logic [1:0]         sense_meta_q;
  logic [1:0]         sense_sync_q;
  logic [31:0]        rd_data;
  logic               rd_hit;
  logic               apb_setup;
  logic               apb_wr;
  logic               cmd_mode;
  logic               both_halves;
  logic               first_half;
  logic               start_sensor;
  logic               next_sensor;
  logic [11:0]        target;
  logic               last_sample;
  logic               sense_sel;
  logic               meas_done;
  logic [TW-1:0]      time1;
  logic [TW-1:0]      time2;
  logic [7:0]         mask1;
  logic [7:0]         mask2;
  logic signed [SW-1:0] sum [2];

  // element pins of one arm
  function automatic logic [7:0] pin_mask(input logic half, input logic elem, input logic sensor,
                                           input logic dual);
    logic [7:0] m;
    m = 8'h00;
    // one pin per element when dual
    if (dual)
      m[{half, elem, sensor}] = 1'b1;
    else
    begin
      m[{half, elem, 1'b0}] = 1'b1;
      m[{half, elem, 1'b1}] = 1'b1;
    end
    return m;
  endfunction : pin_mask

  assign apb_setup = psel_in && !penable_in;
  assign apb_wr    = psel_in && penable_in && pready_out && pwrite_in;

  // second count selects the dual sequencing mode
  assign cmd_mode = cfg_q.dual && (avg2_q != 12'h000);

  always_comb
  begin
    both_halves  = 1'b1;
    first_half   = 1'b0;
    start_sensor = 1'b0;
    next_sensor  = 1'b0;
    sense_sel    = half_q;
    if (!cfg_q.dual)
    begin
      both_halves = (cfg_q.sel == 2'd0) || (cfg_q.sel == 2'd3);
      first_half  = (cfg_q.sel == 2'd2);
      sense_sel   = (cfg_q.sel == 2'd0) ? 1'b0 : half_q;
    end
    else
    begin
      sense_sel = (cfg_q.sel == 2'd3) ? sensor_q : 1'b0;
      // single sensor in auto mode is honoured as a test setting
      if (cfg_q.sel == 2'd1)
      begin
        start_sensor = 1'b0;
        next_sensor  = 1'b0;
      end
      else if (cfg_q.sel == 2'd2)
      begin
        start_sensor = 1'b1;
        next_sensor  = 1'b1;
      end
      // command mode follows the last selection
      else if (cmd_mode)
      begin
        start_sensor = cmd_sensor_q;
        next_sensor  = cmd_sensor_q;
      end
      // auto mode swaps sensors by itself
      else
        next_sensor = !sensor_q;
    end
  end

  assign target      = (cmd_mode && sensor_q) ? avg2_q : ((avg1_q == 12'h000) ? 12'h001 : avg1_q);
  assign last_sample = ({1'b0, sample_q} + 13'd1) >= {1'b0, target};

  // comparator inputs through two flops
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      sense_meta_q <= 2'b11;
      sense_sync_q <= 2'b11;
    end
    else
    begin
      sense_meta_q <= comparator_input_pin_in;
      sense_sync_q <= sense_meta_q;
    end
  end

  // apb register writes
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      cfg_q        <= bms_pkg::bms_cfg_t'(`BMS_CFG_RST);
      classic_q    <= 1'b0;
      avg1_q       <= `BMS_AVG1_RST;
      avg2_q       <= `BMS_AVG2_RST;
      cycle_q      <= `BMS_CYCLE_RST;
      cmd_sensor_q <= 1'b0;
    end
    else if (apb_wr)
    begin
      unique case (paddr_in)
        `BMS_OFS_CONFIG:  cfg_q <= bms_pkg::bms_cfg_t'(pwdata_in[`BMS_CFG_WIDTH-1:0]);
        // classic divider enable, independent of sequencing
        `BMS_OFS_CLASSIC: classic_q <= pwdata_in[0];
        `BMS_OFS_AVG1:    avg1_q <= pwdata_in[11:0];
        `BMS_OFS_AVG2:    avg2_q <= pwdata_in[11:0];
        `BMS_OFS_CYCLE:   cycle_q <= pwdata_in[15:0];
        `BMS_OFS_COMMAND:
        begin
          // sensor opcodes only in command mode
          if (cmd_mode && (pwdata_in[7:0] == `BMS_OP_SENSOR1))
            cmd_sensor_q <= 1'b0;
          else if (cmd_mode && (pwdata_in[7:0] == `BMS_OP_SENSOR2))
            cmd_sensor_q <= 1'b1;
        end
        default: ;
      endcase
    end
  end

  // apb read decode
  always_comb
  begin
    rd_hit  = 1'b1;
    rd_data = 32'h0000_0000;
    unique case (paddr_in)
      `BMS_OFS_CONFIG:  rd_data = {27'h0, cfg_q};
      `BMS_OFS_CLASSIC: rd_data = {31'h0, classic_q};
      `BMS_OFS_AVG1:    rd_data = {20'h0, avg1_q};
      `BMS_OFS_AVG2:    rd_data = {20'h0, avg2_q};
      `BMS_OFS_CYCLE:   rd_data = {16'h0, cycle_q};
      `BMS_OFS_COMMAND: rd_data = {31'h0, cmd_sensor_q};
      `BMS_OFS_STATUS:
      begin
        rd_data[`BMS_STAT_FLAG_BIT] = result_flag_out;
        rd_data[`BMS_STAT_BUSY_BIT] = (st_q != bms_pkg::BMS_IDLE);
        rd_data[`BMS_STAT_SENS_BIT] = status_sensor_q;
      end
      `BMS_OFS_RESULT0: rd_data = 32'(result0_q);
      `BMS_OFS_RESULT1: rd_data = 32'(result1_q);
      `BMS_OFS_RESULT:  rd_data = 32'(result_q);
      default:          rd_hit = 1'b0;
    endcase
  end

  // apb answer: one access cycle, data captured in setup
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h0000_0000;
    end
    else
    begin
      pready_out  <= apb_setup;
      pslverr_out <= apb_setup && !rd_hit;
      if (apb_setup && !pwrite_in)
        prdata_out <= rd_hit ? rd_data : 32'h0000_0000;
    end
  end

  // measurement sequence
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      st_q     <= bms_pkg::BMS_IDLE;
      half_q   <= 1'b0;
      sensor_q <= 1'b0;
      sample_q <= 12'h000;
      timer_q  <= 16'h0000;
    end
    else
    begin
      unique case (st_q)
        bms_pkg::BMS_IDLE:
        begin
          if (cfg_q.run)
          begin
            st_q     <= bms_pkg::BMS_WAIT;
            half_q   <= first_half;
            sensor_q <= start_sensor;
            sample_q <= 12'h000;
            timer_q  <= 16'h0000;
          end
        end
        // one cycle time for every sensor
        bms_pkg::BMS_WAIT:
        begin
          if (!cfg_q.run)
            st_q <= bms_pkg::BMS_IDLE;
          else if (timer_q == 16'h0000)
            st_q <= bms_pkg::BMS_START;
          else
            timer_q <= timer_q - 16'h0001;
        end
        bms_pkg::BMS_START:
          st_q <= bms_pkg::BMS_MEAS;
        bms_pkg::BMS_MEAS:
        begin
          if (meas_done)
          begin
            if (both_halves && !half_q)
            begin
              half_q <= 1'b1;
              st_q   <= bms_pkg::BMS_START;
            end
            else
            begin
              half_q <= first_half;
              if (last_sample)
                st_q <= bms_pkg::BMS_DONE;
              else
              begin
                sample_q <= sample_q + 12'h001;
                timer_q  <= cycle_q;
                st_q     <= bms_pkg::BMS_WAIT;
              end
            end
          end
        end
        bms_pkg::BMS_DONE:
        begin
          sensor_q <= next_sensor;
          sample_q <= 12'h000;
          timer_q  <= cycle_q;
          st_q     <= cfg_q.run ? bms_pkg::BMS_WAIT : bms_pkg::BMS_IDLE;
        end
        default:
          st_q <= bms_pkg::BMS_IDLE;
      endcase
    end
  end

  // results, flag and sensor identity
  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      result0_q       <= '0;
      result1_q       <= '0;
      result_q        <= '0;
      result_flag_out <= 1'b0;
      status_sensor_q <= 1'b0;
      sensor_id_out   <= 1'b0;
    end
    else
    begin
      if (st_q == bms_pkg::BMS_DONE)
      begin
        result0_q <= sum[0];
        result1_q <= sum[1];
        // difference or sum of the halves
        if (both_halves)
          result_q <= cfg_q.diff ? sum[0] - sum[1] : sum[0] + sum[1];
        else
          result_q <= first_half ? sum[1] : sum[0];
        status_sensor_q <= sensor_q;
        sensor_id_out   <= sensor_q;
      end
      // flag set wins over software clear
      if (st_q == bms_pkg::BMS_DONE)
        result_flag_out <= 1'b1;
      else if (apb_wr && (paddr_in == `BMS_OFS_STATUS) && pwdata_in[`BMS_STAT_FLAG_BIT])
        result_flag_out <= 1'b0;
    end
  end

  assign mask1 = pin_mask(half_q, 1'b0, sensor_q, cfg_q.dual);
  assign mask2 = pin_mask(half_q, 1'b1, sensor_q, cfg_q.dual);

  bms_discharge #(
    .TW (TW)
  ) u_discharge (
    .clock_in   (clock_in),
    .rst_in     (rst_in),
    .start_in   (st_q == bms_pkg::BMS_START),
    .mask1_in   (mask1),
    .mask2_in   (mask2),
    .classic_in (classic_q),
    .port_in    (sense_sel),
    .sense_in   (sense_sync_q[sense_sel]),
    .elem_out   (element_pin_out),
    .charge_out (capacitor_charge_pin_out),
    .time1_out  (time1),
    .time2_out  (time2),
    .done_out   (meas_done)
  );

  for (genvar g = 0; g < 2; g++)
  begin : g_half
    bms_average #(
      .TW (TW),
      .SW (SW)
    ) u_average (
      .clock_in (clock_in),
      .rst_in   (rst_in),
      .clr_in   ((st_q == bms_pkg::BMS_IDLE) || (st_q == bms_pkg::BMS_DONE)),
      .add_in   ((st_q == bms_pkg::BMS_MEAS) && meas_done && (half_q == 1'(g))),
      .t1_in    (time1),
      .t2_in    (time2),
      .sum_out  (sum[g])
    );
  end

  default clocking @(posedge clock_in);
  endclocking
  default disable iff (rst_in);

  sequence s_first_half_done;
    st_q == bms_pkg::BMS_MEAS && meas_done && both_halves && !half_q;
  endsequence

  sequence s_second_half_start;
    st_q == bms_pkg::BMS_START && half_q ##1 st_q == bms_pkg::BMS_MEAS;
  endsequence

  a_interleave_halves: assert property (s_first_half_done |=> s_second_half_start)
    else $error("second half not measured after first");

  a_flag_after_result: assert property (st_q == bms_pkg::BMS_DONE |=> result_flag_out ##1 result_flag_out)
    else $error("result flag not set after result");

  a_status_sensor_id: assert property (st_q == bms_pkg::BMS_DONE |=> status_sensor_q == $past(sensor_q))
    else $error("status sensor bit wrong");

  a_auto_alternate: assert property (st_q == bms_pkg::BMS_DONE && cfg_q.dual && !cmd_mode && (cfg_q.sel[0] == cfg_q.sel[1])
                                     |=> sensor_q != $past(sensor_q))
    else $error("auto mode did not switch sensor");

  a_cmd_follow_sel: assert property (st_q == bms_pkg::BMS_DONE && cmd_mode && cfg_q.sel inside {2'd0, 2'd3}
                                     |=> sensor_q == $past(cmd_sensor_q))
    else $error("command selection not followed");

  a_cmd_ignored: assert property (apb_wr && paddr_in == `BMS_OFS_COMMAND && !cmd_mode |=> $stable(cmd_sensor_q))
    else $error("opcode acted on outside command mode");

  a_half_only: assert property (st_q == bms_pkg::BMS_START && !cfg_q.dual && cfg_q.sel == 2'd2 |-> half_q
                                ##1 !both_halves)
    else $error("half 2 only mode measured half 1");

  a_dual_one_pin: assert property (st_q == bms_pkg::BMS_START && cfg_q.dual |-> $onehot(mask1) && $onehot(mask2))
    else $error("dual mode drives paired pins");

  a_cmd_second_count: assert property (st_q == bms_pkg::BMS_DONE && cmd_mode && sensor_q
                                       |-> sample_q == avg2_q - 12'h001)
    else $error("sensor 2 averaged with wrong count");

  a_diff_result: assert property (st_q == bms_pkg::BMS_DONE && both_halves && cfg_q.diff
                                  |=> result_q == $past(sum[0]) - $past(sum[1]))
    else $error("difference result wrong");

endmodule : bms_sequencer
